// file: src/smc_pkg.sv
// sleep-mode controller package: register layout, modes, timing counts
// assumes a 10 MHz system clock and a plain strobe register port
`default_nettype none
package smc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [1:0] ADDR_POWER_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_WAKE_CFG    = 2'h1;
  localparam logic [1:0] ADDR_STATUS      = 2'h2;
  localparam logic [7:0] POWER_CTRL_RESET = 8'h00;
  localparam logic [7:0] WAKE_CFG_RESET   = 8'h00;
  localparam int         SM2_POS          = 7;
  localparam int         SE_POS           = 6;
  localparam int         SM1_POS          = 5;
  localparam int         SM0_POS          = 4;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int         CLK_HZ           = 10_000_000;
  localparam int         HALT_EXTRA_CYC   = 4;
  localparam int         STANDBY_WAKE_CYC = 6;
  localparam logic [15:0] STARTUP_DEFAULT = 16'h0006;

  typedef enum logic [2:0] {
    MODE_IDLE     = 3'h0,
    MODE_NOISE    = 3'h1,
    MODE_PDOWN    = 3'h2,
    MODE_PSAVE    = 3'h3,
    MODE_RSVD4    = 3'h4,
    MODE_RSVD5    = 3'h5,
    MODE_STANDBY  = 3'h6,
    MODE_XSTANDBY = 3'h7
  } smc_mode_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STARTUP,
    ST_HALT
  } smc_state_t;

  // wake sources, all from logic on clk_sys
  typedef struct packed {
    logic convDone;
    logic twoWireMatch;
    logic asyncTimerIrq;
    logic memReady;
    logic extLevel01;
    logic extLine2;
    logic otherIo;
  } smc_wake_t;

  // clock domain enables
  typedef struct packed {
    logic coreClk;
    logic flashClk;
    logic periphClk;
    logic convClk;
    logic asyncClk;
    logic mainOsc;
  } smc_clk_t;

  typedef struct packed {
    smc_state_t state;
    logic [7:0] powerCtrl;
    logic [7:0] wakeCfg;
    smc_mode_t  mode;
    logic [15:0] count;
    logic [7:0] rdata;
    logic       convStart;
    logic       irqGo;
    logic       resumedByReset;
  } smc_regs_t;

endpackage : smc_pkg
`default_nettype wire

// file: src/smc_sleep_mode_controller.sv
// sleep-mode controller: enters sleep on halt with the enable bit set, gates clock domains
// per mode and wakes on the sources that mode allows; assumes the core pulses haltExec
//
// Overview of operation
// - sleep only on halt with enable set
// - mode field at bits 7, 5, 4
// - interrupt wake: four extra halt cycles
// - register file and RAM untouched by sleep
// - reset during sleep restarts from vector
// - idle gates only core and flash clocks
// - idle wakes on any enabled interrupt
// - converter enabled: idle/noise starts conversion
// - noise mode gates I/O, core, flash
// - noise mode limited wake source list
// - power-down stops oscillator and clocks
// - power-down limited wake source list
// - power-down wake waits fuse start-up delay
// - power-save keeps async timer if selected
// - power-save timer wake needs mask, global
// - synchronous async timer undefined after save
// - standby: oscillator on, six-cycle wake
// - extended standby: same, six-cycle wake
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module smc_sleep_mode_controller (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [1:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [7:0]       regRdata,
  input  wire logic             haltExec,
  input  wire smc_pkg::smc_wake_t wakeReq,
  input  wire logic             sysResetReq,
  input  wire logic             convEnabled,
  input  wire logic             asyncTimerClockSelect,
  input  wire logic             asyncTimerIrqMasked,
  input  wire logic             globalIrqEnable,
  input  wire logic             crystalSource,
  input  wire logic [15:0]      startupCycles,
  output smc_pkg::smc_clk_t     clkEnable,
  output logic                  coreHold,
  output logic                  irqService,
  output logic                  convStart,
  output logic                  resetResume,
  output logic                  asyncTimerUndefined
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // per mode wake filter; reserved codes accept only reset
  function automatic logic wakeAllowed(input smc_pkg::smc_mode_t m,
                                       input smc_pkg::smc_wake_t w,
                                       input logic timerOk);
    logic common;
    common = w.twoWireMatch | w.extLevel01 | w.extLine2;
    unique case (m)
      smc_pkg::MODE_IDLE:     wakeAllowed = |w;
      smc_pkg::MODE_NOISE:    wakeAllowed = common | w.convDone | w.asyncTimerIrq
                                            | w.memReady;
      smc_pkg::MODE_PDOWN,
      smc_pkg::MODE_STANDBY:  wakeAllowed = common;
      smc_pkg::MODE_PSAVE,
      smc_pkg::MODE_XSTANDBY: wakeAllowed = common | (w.asyncTimerIrq & timerOk);
      default:                wakeAllowed = 1'b0;
    endcase
  endfunction : wakeAllowed

  // clocks that keep running while asleep in a mode
  function automatic smc_pkg::smc_clk_t sleepClocks(input smc_pkg::smc_mode_t m,
                                                    input logic asy);
    smc_pkg::smc_clk_t c;
    c = '0;
    unique case (m)
      smc_pkg::MODE_IDLE:     c = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
      smc_pkg::MODE_NOISE:    c = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      smc_pkg::MODE_PDOWN:    c = '0;
      smc_pkg::MODE_PSAVE:    c.asyncClk = asy;
      smc_pkg::MODE_STANDBY:  c.mainOsc = 1'b1;
      smc_pkg::MODE_XSTANDBY:
      begin
        c.mainOsc = 1'b1;
        c.asyncClk = asy;
      end
      default:                c = '0;
    endcase
    return c;
  endfunction : sleepClocks

  // standby codes need a crystal to keep the oscillator alive; without one they
  // fall back to the matching deep mode, so the oscillator is never left running
  function automatic smc_pkg::smc_mode_t effMode(input smc_pkg::smc_mode_t m,
                                                 input logic xtal);
    smc_pkg::smc_mode_t e;
    e = m;
    if (!xtal && m == smc_pkg::MODE_STANDBY)
      e = smc_pkg::MODE_PDOWN;
    if (!xtal && m == smc_pkg::MODE_XSTANDBY)
      e = smc_pkg::MODE_PSAVE;
    return e;
  endfunction : effMode

  // shared by the start-up and extra halt phases
  function automatic logic [15:0] countDown(input logic [15:0] cnt);
    return cnt - 16'h0001;
  endfunction : countDown

  function automatic logic lastCycle(input logic [15:0] cnt);
    return cnt == 16'h0001;
  endfunction : lastCycle

  // ****************************************************************
  // state
  // ****************************************************************
  smc_pkg::smc_regs_t r_q;
  smc_pkg::smc_regs_t r_d;
  smc_pkg::smc_mode_t selMode;
  logic               timerOk;

  assign selMode = smc_pkg::smc_mode_t'({r_q.powerCtrl[smc_pkg::SM2_POS],
                                         r_q.powerCtrl[smc_pkg::SM1_POS],
                                         r_q.powerCtrl[smc_pkg::SM0_POS]});
  assign timerOk = asyncTimerClockSelect & asyncTimerIrqMasked & globalIrqEnable;

  always_comb
  begin
    r_d = r_q;
    r_d.convStart = 1'b0;
    r_d.irqGo = 1'b0;
    r_d.rdata = 8'h00;
    if (regWr)
    begin
      unique case (regAddr)
        smc_pkg::ADDR_POWER_CTRL: r_d.powerCtrl = regWdata;
        smc_pkg::ADDR_WAKE_CFG:   r_d.wakeCfg = regWdata;
        default:                  ;
      endcase
    end
    if (regRd)
    begin
      unique case (regAddr)
        smc_pkg::ADDR_POWER_CTRL: r_d.rdata = r_q.powerCtrl;
        smc_pkg::ADDR_WAKE_CFG:   r_d.rdata = r_q.wakeCfg;
        smc_pkg::ADDR_STATUS:     r_d.rdata = {3'h0, r_q.resumedByReset, 1'b0, r_q.mode} |
                                              {r_q.state, 6'h00};
        default:                  r_d.rdata = 8'h00;
      endcase
    end
    unique case (r_q.state)
      smc_pkg::ST_RUN:
      begin
        // no enable bit, no sleep: halt acts as a no-op
        if (haltExec && r_q.powerCtrl[smc_pkg::SE_POS])
        begin
          r_d.state = smc_pkg::ST_SLEEP;
          r_d.mode = effMode(selMode, crystalSource);
          r_d.resumedByReset = 1'b0;
          if (convEnabled && (selMode == smc_pkg::MODE_IDLE || selMode == smc_pkg::MODE_NOISE))
            r_d.convStart = 1'b1;
        end
      end
      smc_pkg::ST_SLEEP:
      begin
        if (wakeAllowed(r_q.mode, wakeReq, timerOk))
        begin
          r_d.state = smc_pkg::ST_STARTUP;
          unique case (r_q.mode)
            smc_pkg::MODE_PDOWN,
            smc_pkg::MODE_PSAVE:    r_d.count = (startupCycles == 16'h0000) ? 16'h0001
                                                : startupCycles;
            smc_pkg::MODE_STANDBY,
            smc_pkg::MODE_XSTANDBY: r_d.count = 16'(smc_pkg::STANDBY_WAKE_CYC);
            default:                r_d.count = 16'h0001;
          endcase
        end
      end
      smc_pkg::ST_STARTUP:
      begin
        r_d.count = countDown(r_q.count);
        if (lastCycle(r_q.count))
        begin
          r_d.state = smc_pkg::ST_HALT;
          r_d.count = 16'(smc_pkg::HALT_EXTRA_CYC);
        end
      end
      smc_pkg::ST_HALT:
      begin
        r_d.count = countDown(r_q.count);
        if (lastCycle(r_q.count))
        begin
          r_d.state = smc_pkg::ST_RUN;
          r_d.irqGo = 1'b1;
        end
      end
    endcase
    // reset from outside while not running restarts at the vector; powerCtrl cleared, wakeCfg untouched
    if (sysResetReq && r_q.state != smc_pkg::ST_RUN)
    begin
      r_d.state = smc_pkg::ST_RUN;
      r_d.powerCtrl = smc_pkg::POWER_CTRL_RESET;
      r_d.resumedByReset = 1'b1;
      r_d.irqGo = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      r_q <= '0;
      r_q.powerCtrl <= smc_pkg::POWER_CTRL_RESET;
      r_q.wakeCfg <= smc_pkg::WAKE_CFG_RESET;
      r_q.state <= smc_pkg::ST_RUN;
      r_q.mode <= smc_pkg::MODE_IDLE;
    end
    else
      r_q <= r_d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_comb
  begin
    if (r_q.state == smc_pkg::ST_SLEEP)
      clkEnable = sleepClocks(r_q.mode, asyncTimerClockSelect);
    else
      clkEnable = '1;
  end

  assign regRdata = r_q.rdata;
  assign coreHold = (r_q.state != smc_pkg::ST_RUN);
  assign irqService = r_q.irqGo;
  assign convStart = r_q.convStart;
  assign resetResume = r_q.resumedByReset;
  // flags a timer that ran synchronously through power-save
  assign asyncTimerUndefined = (r_q.state != smc_pkg::ST_RUN) &&
                               (r_q.mode == smc_pkg::MODE_PSAVE) && !asyncTimerClockSelect;

endmodule : smc_sleep_mode_controller
`default_nettype wire

// file: verification/smc_props.sv
// port checker for the sleep-mode controller
// assumes binding onto smc_sleep_mode_controller, one clock
`timescale 1ns/1ns
`default_nettype none
module smc_props (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic [1:0]        regAddr,
  input wire logic [7:0]        regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [7:0]        regRdata,
  input wire logic              haltExec,
  input wire logic              sysResetReq,
  input wire smc_pkg::smc_clk_t clkEnable,
  input wire logic              coreHold,
  input wire logic              irqService,
  input wire logic              convStart,
  input wire logic              resetResume
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // shadow of the enable bit; a reset wake clears the register
  logic seQ;
  always_ff @(posedge clk_sys)
    if (rst || (sysResetReq && coreHold)) seQ <= 1'b0;
    else if (regWr && regAddr == smc_pkg::ADDR_POWER_CTRL) seQ <= regWdata[smc_pkg::SE_POS];
  a_sleep_entry: assert property (haltExec && !coreHold && seQ && !sysResetReq |=> coreHold)
    else $error("halt with enable set did not sleep");
  a_run_stays: assert property (!coreHold && !(haltExec && seQ) |=> !coreHold)
    else $error("core stopped without an enabled halt");
  a_gate_pair: assert property (!clkEnable.coreClk |-> coreHold && !clkEnable.flashClk)
    else $error("core and flash clocks not gated together");
  a_wake_hold: assert property (irqService |-> !coreHold && $past(coreHold) && $past(coreHold, 5))
    else $error("interrupt taken without extra halt cycles");
  a_irq_single: assert property (irqService |=> !irqService)
    else $error("interrupt service pulse too long");
  a_conv_entry: assert property (convStart |-> !clkEnable.coreClk && clkEnable.convClk ##1 !convStart)
    else $error("conversion start outside sleep entry");
  a_reset_wake: assert property (coreHold && sysResetReq |-> ##[1:2] (!coreHold && resetResume && !irqService))
    else $error("reset during sleep did not restart");
  a_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
endmodule : smc_props
bind smc_sleep_mode_controller smc_props i_props (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .haltExec(haltExec),
  .sysResetReq(sysResetReq), .clkEnable(clkEnable), .coreHold(coreHold), .irqService(irqService),
  .convStart(convStart), .resetResume(resetResume));
`default_nettype wire

// file: verification/smc_sleep_mode_controller_test.sv
// bench for the sleep-mode controller: registers, every non-reserved mode, wake timing, reset wake
// assumes package and controller compiled first
`timescale 1ns/1ns
`default_nettype none
module smc_sleep_mode_controller_test;
  // clock enables {core,flash,periph,conv,async,osc} and one allowed wake source per mode
  localparam logic [5:0] CE [8] = '{6'h0f, 6'h07, 6'h00, 6'h02, 6'h00, 6'h00, 6'h01, 6'h03};
  localparam logic [6:0] SRC [8] = '{7'h01, 7'h40, 7'h02, 7'h10, 7'h00, 7'h00, 7'h04, 7'h20};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0, regRd = 1'b0, haltExec = 1'b0, sysResetReq = 1'b0;
  logic convEn = 1'b1, asySel = 1'b1, irqMask = 1'b1, gie = 1'b1, xtal = 1'b1; // crystal on for standby
  logic [15:0] startup = 16'h0003;
  smc_pkg::smc_wake_t wakeReq = '0;
  smc_pkg::smc_clk_t clkEnable;
  logic [7:0] regRdata;
  logic coreHold, irqService, convStart, resetResume, asyUndef;
  int error_cnt = 0;
  int checks = 0;
  always #50 clk_sys = ~clk_sys;
  smc_sleep_mode_controller i_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .haltExec(haltExec), .wakeReq(wakeReq),
    .sysResetReq(sysResetReq), .convEnabled(convEn), .asyncTimerClockSelect(asySel),
    .asyncTimerIrqMasked(irqMask), .globalIrqEnable(gie), .crystalSource(xtal), .startupCycles(startup),
    .clkEnable(clkEnable), .coreHold(coreHold), .irqService(irqService), .convStart(convStart),
    .resetResume(resetResume), .asyncTimerUndefined(asyUndef));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    chk("regRdata", regRdata, e);
  endtask : rd
  task automatic halt;
    @(posedge clk_sys);
    haltExec <= 1'b1;
    @(posedge clk_sys);
    haltExec <= 1'b0;
    #1;
  endtask : halt
  // holds the wake level until the interrupt is taken, then checks the delay
  task automatic wake(input smc_pkg::smc_wake_t src, input int startCyc);
    int n;
    n = 0;
    @(posedge clk_sys);
    wakeReq <= src;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (irqService !== 1'b1 && n < 40);
    @(posedge clk_sys);
    wakeReq <= '0;
    chk("wake cycles", 16'(n), 16'(1 + smc_pkg::HALT_EXTRA_CYC + startCyc));
  endtask : wake
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_basic;
    chk("clkEnable", clkEnable, 6'h3f);
    rd(smc_pkg::ADDR_POWER_CTRL, smc_pkg::POWER_CTRL_RESET);
    rd(2'h3, 8'h00);
    wr(smc_pkg::ADDR_WAKE_CFG, 8'h5a);
    rd(smc_pkg::ADDR_WAKE_CFG, 8'h5a);
    // status is read-only: a write must leave it at its idle value
    wr(smc_pkg::ADDR_STATUS, 8'hff);
    rd(smc_pkg::ADDR_STATUS, 8'h00);
    // all mode bits set but enable clear: halt must be ignored
    wr(smc_pkg::ADDR_POWER_CTRL, 8'hb0);
    halt();
    repeat (3) @(posedge clk_sys);
    #1;
    chk("coreHold", coreHold, 1'b0);
  endtask : t_basic
  task automatic t_modes;
    for (int i = 0; i < 8; i++)
    begin
      // reserved encodings are left alone, as software must
      if (i == 4 || i == 5)
        continue;
      wr(smc_pkg::ADDR_POWER_CTRL, {i[2], 1'b1, i[1:0], 4'h0});
      halt();
      chk("clkEnable", clkEnable, CE[i]);
      chk("convStart", convStart, 16'(i < 2));
      if (i != 0)
      begin
        // sources outside the mode's list; timer blocked by global flag or by mask
        @(posedge clk_sys);
        gie <= (i == 7);
        irqMask <= (i != 7);
        wakeReq <= (i == 3 || i == 7) ? 7'h11 : 7'h01;
        repeat (4) @(posedge clk_sys);
        wakeReq <= '0;
        gie <= 1'b1;
        irqMask <= 1'b1;
        #1;
        chk("coreHold", coreHold, 1'b1);
      end
      wake(SRC[i], (i < 2) ? 1 : (i > 5) ? smc_pkg::STANDBY_WAKE_CYC : int'(startup));
      wr(smc_pkg::ADDR_POWER_CTRL, 8'h00);
    end
  endtask : t_modes
  task automatic t_options;
    @(posedge clk_sys);
    convEn <= 1'b0;
    xtal <= 1'b0;
    wr(smc_pkg::ADDR_POWER_CTRL, 8'h40);
    halt();
    chk("convStart", convStart, 1'b0);
    wake(7'h01, 1);
    // standby code without a crystal behaves as power-down
    wr(smc_pkg::ADDR_POWER_CTRL, 8'he0);
    halt();
    chk("clkEnable", clkEnable, 6'h00);
    wake(7'h04, int'(startup));
    wr(smc_pkg::ADDR_POWER_CTRL, 8'h00);
    @(posedge clk_sys);
    convEn <= 1'b1;
    xtal <= 1'b1;
  endtask : t_options
  task automatic t_reset_wake;
    @(posedge clk_sys);
    asySel <= 1'b0;
    wr(smc_pkg::ADDR_POWER_CTRL, 8'h70);
    halt();
    chk("asyUndef", asyUndef, 1'b1);
    rd(smc_pkg::ADDR_STATUS, 8'h43);
    @(posedge clk_sys);
    sysResetReq <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sysResetReq <= 1'b0;
    asySel <= 1'b1;
    #1;
    chk("coreHold", coreHold, 1'b0);
    chk("resetResume", resetResume, 1'b1);
    rd(smc_pkg::ADDR_POWER_CTRL, 8'h00);
    rd(smc_pkg::ADDR_STATUS, 8'h13);
  endtask : t_reset_wake
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_basic();
    t_modes();
    t_options();
    t_reset_wake();
    complete_run();
  end
  // a few hundred cycles are expected; cut a hang well after that
  initial
  begin
    #(100 * 5000);
    error_cnt++;
    complete_run();
  end
endmodule : smc_sleep_mode_controller_test
`default_nettype wire
